// ---- gpp_pkg.sv ----
// Package: register map, field layout and counts of the grayscale PWM block
`default_nettype none
package gpp_pkg;
    localparam int NUM_CH = 16;
    localparam int GS_W = 12;
    localparam int DC_W = 6;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] FAULT_OFS = 8'h08;
    localparam logic [7:0] SINK_OFS = 8'h0c;
    localparam logic [7:0] GS_BASE = 8'h40;
    localparam logic [7:0] DC_BASE = 8'h80;
    localparam logic [1:0] ARRAY_SEL_GS = 2'h1;
    localparam logic [1:0] ARRAY_SEL_DC = 2'h2;

    // Control register fields
    localparam int CTRL_START_DONE_BIT = 0;
    localparam int CTRL_ENABLE_BIT = 1;

    // Status register fields
    localparam int STAT_COUNT_LSB = 0;
    localparam int STAT_BUS_PRECHARGE_PHASE_BIT = 16;
    localparam int STAT_ACTIVE_BIT = 17;
    localparam int STAT_LED_AMP_BIT = 18;

    // Values after reset
    localparam logic RST_ENABLE = 1'b0;
    localparam logic RST_START_DONE = 1'b0;
    localparam logic [GS_W-1:0] RST_GS = 12'h000;
    localparam logic [DC_W-1:0] RST_DC = 6'h00;
    localparam logic [GS_W-1:0] RST_COUNT = 12'h000;

    // Dimming period counts
    localparam logic [GS_W-1:0] COUNT_FIRST = 12'h001;
    localparam logic [GS_W-1:0] COUNT_BUS_PRECHARGE_PHASE_FROM = 12'he01;
    localparam int PERIOD_CNT = 4096;
    localparam int TRACK_CNT = 3584;

    typedef struct packed {
        logic feedback_error_amp;
        logic led_pin_error_amp;
        logic bus_precharge_phase;
    } gpp_loop_t;

    typedef struct packed {
        logic [NUM_CH-1:0] sink_on;
        logic [NUM_CH*DC_W-1:0] dot_corr;
    } gpp_sink_t;
endpackage : gpp_pkg
`default_nettype wire

// ---- gpp_sync.sv ----
// Three-stage pin synchroniser; a change passes once stages 2 and 3 agree
`default_nettype none
module gpp_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] din,
    output var logic [W-1:0] dout
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] next_dout;

    always_comb begin
        for (int i = 0; i < W; i++) begin
            next_dout[i] = (s2[i] == s3[i]) ? s3[i] : dout[i];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            dout <= '0;
        end else begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
            dout <= next_dout;
        end
    end
endmodule : gpp_sync
`default_nettype wire

// ---- gpp_top.sv ----
// Grayscale PWM sequencer: dot correction, precharge phase, APB registers
// Operation
// (RULE_01) Each channel keeps a 6-bit dot-correction code driven to its sink.
// (RULE_02) One shared counter times all channels; rising edges coincide.
// (RULE_03) A channel sink is on while its dimming waveform is high.
// (RULE_04) Duty follows the 12-bit grayscale value; period 4096 clocks.
// (RULE_05) After enable, first edge steps 0 to 1, lights nonzero channels.
// (RULE_06) Every later dimming edge adds exactly one to the counter.
// (RULE_07) A channel turns off when the counter equals its grayscale value.
// (RULE_08) Outside logic may stop the dimming clock to hold full duty.
// (RULE_09) Clearing enable zeroes the counter and turns all sinks off.
// (RULE_10) Precharge is low for 3584 dimming clocks, high for the last 512.
// (RULE_11) Precharge rises early when no channel is on and unfaulted.
// (RULE_12) Low precharge selects LED-pin amp, high selects feedback amp.
// (RULE_13) LED-pin amplifier stays disabled until startup is marked done.
// (RULE_14) Command bit one enables all channels when one, disables when zero.
// (RULE_15) Reset clears enable, every grayscale and dot-correction value.
// (RULE_16) Counter wraps after 4095; next edge starts a new period.
`default_nettype none
module gpp_top (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [gpp_pkg::ADDR_W-1:0] PADDR,
    input wire logic [gpp_pkg::DATA_W-1:0] PWDATA,
    output logic [gpp_pkg::DATA_W-1:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic DIMMING_COUNT_CLOCK,
    input wire logic [gpp_pkg::NUM_CH-1:0] LED_FAULT,
    output gpp_pkg::gpp_sink_t SINK,
    output gpp_pkg::gpp_loop_t LOOP_SEL
);
    localparam int NCH = gpp_pkg::NUM_CH;
    localparam int GW = gpp_pkg::GS_W;
    localparam int DW = gpp_pkg::DC_W;

    ////////////////////////////////////////////////////////////////////////
    // Reset release
    logic rst_m;
    logic rst_n;

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_m <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_m <= 1'b1;
            rst_n <= rst_m;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin inputs
    logic dim_lvl;
    logic dim_lvl_q;
    logic dim_edge;
    logic [NCH-1:0] fault;

    gpp_sync #(.W(1)) u_dim_sync (
        .clk(CLK),
        .rst_n(rst_n),
        .din(DIMMING_COUNT_CLOCK),
        .dout(dim_lvl)
    );

    gpp_sync #(.W(NCH)) u_fault_sync (
        .clk(CLK),
        .rst_n(rst_n),
        .din(LED_FAULT),
        .dout(fault)
    );

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            dim_lvl_q <= 1'b0;
        end else begin
            dim_lvl_q <= dim_lvl;
        end
    end

    assign dim_edge = dim_lvl & ~dim_lvl_q;

    ////////////////////////////////////////////////////////////////////////
    // APB register file
    logic enable;
    logic start_done;
    logic [GW-1:0] gs [NCH];
    logic [DW-1:0] dc [NCH];
    logic [gpp_pkg::DATA_W-1:0] rdata;
    logic rerr;
    logic next_enable;
    logic next_start_done;
    logic [GW-1:0] next_gs [NCH];
    logic [DW-1:0] next_dc [NCH];
    logic [gpp_pkg::DATA_W-1:0] next_rdata;
    logic next_rerr;
    logic setup;
    logic wr_take;
    logic [3:0] idx;
    logic [1:0] arr;
    logic is_array;
    logic hit;

    logic [GW-1:0] count;
    logic [NCH-1:0] sink_on;
    logic precharge;
    logic any_active;
    logic led_amp_en;

    assign setup = PSEL & ~PENABLE;
    // Write lands at the access-phase edge; the slave never waits
    assign wr_take = PSEL & PENABLE & PWRITE & ~rerr;
    assign idx = PADDR[5:2];
    assign arr = PADDR[7:6];
    assign is_array = (arr == gpp_pkg::ARRAY_SEL_GS)
        || (arr == gpp_pkg::ARRAY_SEL_DC);
    assign hit = is_array
        || (PADDR == gpp_pkg::CTRL_OFS)
        || (PADDR == gpp_pkg::STATUS_OFS)
        || (PADDR == gpp_pkg::FAULT_OFS)
        || (PADDR == gpp_pkg::SINK_OFS);

    always_comb begin
        next_enable = enable;
        next_start_done = start_done;
        next_gs = gs;
        next_dc = dc;
        next_rdata = rdata;
        next_rerr = rerr;
        if (setup) begin
            // Decode in setup so data and error stand for the access phase
            next_rerr = ~hit | (PADDR[1:0] != 2'h0);
            next_rdata = '0;
            if (arr == gpp_pkg::ARRAY_SEL_GS) begin
                next_rdata[GW-1:0] = gs[idx];
            end else if (arr == gpp_pkg::ARRAY_SEL_DC) begin
                next_rdata[DW-1:0] = dc[idx];
            end else if (PADDR == gpp_pkg::CTRL_OFS) begin
                next_rdata[gpp_pkg::CTRL_ENABLE_BIT] = enable;
                next_rdata[gpp_pkg::CTRL_START_DONE_BIT] = start_done;
            end else if (PADDR == gpp_pkg::STATUS_OFS) begin
                next_rdata[gpp_pkg::STAT_COUNT_LSB +: GW] = count;
                next_rdata[gpp_pkg::STAT_BUS_PRECHARGE_PHASE_BIT] = precharge;
                next_rdata[gpp_pkg::STAT_ACTIVE_BIT] = any_active;
                next_rdata[gpp_pkg::STAT_LED_AMP_BIT] = led_amp_en;
            end else if (PADDR == gpp_pkg::FAULT_OFS) begin
                next_rdata[NCH-1:0] = fault;
            end else if (PADDR == gpp_pkg::SINK_OFS) begin
                next_rdata[NCH-1:0] = sink_on;
            end
        end
        if (wr_take) begin
            if (arr == gpp_pkg::ARRAY_SEL_GS) begin
                next_gs[idx] = PWDATA[GW-1:0];
            end else if (arr == gpp_pkg::ARRAY_SEL_DC) begin
                next_dc[idx] = PWDATA[DW-1:0]; // RULE_01
            end else if (PADDR == gpp_pkg::CTRL_OFS) begin
                next_enable = PWDATA[gpp_pkg::CTRL_ENABLE_BIT]; // RULE_14
                next_start_done = PWDATA[gpp_pkg::CTRL_START_DONE_BIT];
            end
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            enable <= gpp_pkg::RST_ENABLE; // RULE_15
            start_done <= gpp_pkg::RST_START_DONE;
            for (int i = 0; i < NCH; i++) begin
                gs[i] <= gpp_pkg::RST_GS; // RULE_15
                dc[i] <= gpp_pkg::RST_DC; // RULE_15
            end
            rdata <= '0;
            rerr <= 1'b0;
        end else begin
            enable <= next_enable;
            start_done <= next_start_done;
            gs <= next_gs;
            dc <= next_dc;
            rdata <= next_rdata;
            rerr <= next_rerr;
        end
    end

    assign PRDATA = rdata;
    assign PREADY = PSEL & PENABLE;
    assign PSLVERR = PSEL & PENABLE & rerr;

    ////////////////////////////////////////////////////////////////////////
    // Shared dimming counter and channel waveforms
    logic [GW-1:0] next_count;
    logic [NCH-1:0] next_sink_on;
    logic next_precharge;
    logic next_led_amp_en;
    logic [NCH-1:0] active_vec;

    always_comb begin
        next_count = count;
        next_sink_on = sink_on;
        if (!next_enable) begin
            // Disable acts in the same edge that takes the write
            next_count = gpp_pkg::RST_COUNT; // RULE_09
            next_sink_on = '0; // RULE_09
        end else if (dim_edge) begin
            // Natural 12-bit wrap after 4095
            next_count = count + gpp_pkg::COUNT_FIRST; // RULE_06 RULE_16
            for (int i = 0; i < NCH; i++) begin
                if (next_count == gpp_pkg::COUNT_FIRST) begin
                    next_sink_on[i] = (gs[i] != '0); // RULE_05 RULE_02
                end else begin
                    // A value of one still gets a single count of light
                    next_sink_on[i] = sink_on[i]
                        & (next_count < gs[i]); // RULE_07 RULE_04
                end
            end
        end
    end

    always_comb begin
        active_vec = next_sink_on & ~fault;
        // Idle count zero belongs to the precharge tail of the period
        next_precharge = (next_count == gpp_pkg::RST_COUNT)
            || (next_count >= gpp_pkg::COUNT_BUS_PRECHARGE_PHASE_FROM) // RULE_10
            || (active_vec == '0); // RULE_11
        next_led_amp_en = start_done & ~next_precharge; // RULE_12 RULE_13
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            count <= gpp_pkg::RST_COUNT;
            sink_on <= '0;
            precharge <= 1'b1;
            led_amp_en <= 1'b0;
            any_active <= 1'b0;
        end else begin
            count <= next_count;
            sink_on <= next_sink_on;
            precharge <= next_precharge;
            led_amp_en <= next_led_amp_en;
            any_active <= |active_vec;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Analog-side outputs
    always_comb begin
        SINK.sink_on = sink_on; // RULE_03
        for (int i = 0; i < NCH; i++) begin
            SINK.dot_corr[i*DW +: DW] = dc[i]; // RULE_01
        end
        LOOP_SEL.bus_precharge_phase = precharge;
        LOOP_SEL.led_pin_error_amp = led_amp_en; // RULE_12
        LOOP_SEL.feedback_error_amp = ~led_amp_en; // RULE_12 RULE_13
    end
endmodule : gpp_top
`default_nettype wire

// ---- gpp_top_props.sv ----
// Checker on the ports of the grayscale PWM block
`default_nettype none
module gpp_top_props (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic DIMMING_COUNT_CLOCK,
    input wire logic [15:0] LED_FAULT,
    input wire gpp_pkg::gpp_sink_t SINK,
    input wire gpp_pkg::gpp_loop_t LOOP_SEL
);
    timeunit 1ns;
    timeprecision 1ps;
    wire acc = PSEL && PENABLE;
    wire wr_ctl = acc && PWRITE && PADDR == gpp_pkg::CTRL_OFS;
    default clocking @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    ready_now_a: assert property (PREADY == acc)
        else $error("pready not tied to access phase");
    err_access_a: assert property (PSLVERR |-> acc)
        else $error("pslverr outside access phase");
    disable_off_a: assert property (wr_ctl && !PWDATA[1] |=>
        SINK.sink_on == 16'h0000) else $error("sinks on after disable");
    amp_inverse_a: assert property (
        LOOP_SEL.feedback_error_amp != LOOP_SEL.led_pin_error_amp)
        else $error("both or no amplifier selected");
    amp_track_a: assert property (
        LOOP_SEL.led_pin_error_amp |-> !LOOP_SEL.bus_precharge_phase)
        else $error("led amp active while precharging");
    idle_bus_precharge_phase_a: assert property (
        (SINK.sink_on == 16'h0000)[*3] |-> LOOP_SEL.bus_precharge_phase)
        else $error("no precharge with all sinks off");
    sink_rise_a: assert property (
        |(SINK.sink_on & ~$past(SINK.sink_on)) |-> DIMMING_COUNT_CLOCK)
        else $error("sink on without dimming edge");
    sink_fall_a: assert property (
        |(~SINK.sink_on & $past(SINK.sink_on)) |->
        DIMMING_COUNT_CLOCK || $past(wr_ctl))
        else $error("sink off without cause");
    dc_hold_a: assert property (
        $changed(SINK.dot_corr) |-> $past(acc && PWRITE))
        else $error("dot correction changed without write");
endmodule : gpp_top_props
bind gpp_top gpp_top_props u_props (.CLK(CLK), .ARST_N(ARST_N),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .DIMMING_COUNT_CLOCK(DIMMING_COUNT_CLOCK), .LED_FAULT(LED_FAULT),
    .SINK(SINK), .LOOP_SEL(LOOP_SEL));
`default_nettype wire

// ---- gpp_led_model.sv ----
// LED strings: an open string reports a fault only while its sink pulls
`default_nettype none
module gpp_led_model (
    input wire logic clk,
    input wire gpp_pkg::gpp_sink_t sink,
    input wire logic [15:0] open_led,
    output logic [15:0] led_fault
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge clk) begin
        led_fault <= open_led & sink.sink_on;
    end
endmodule : gpp_led_model
`default_nettype wire

// ---- tb.sv ----
// Testbench: APB accesses and a full dimming period
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, dim = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, err;
    logic [15:0] led_fault, open_led = 16'h0000;
    gpp_pkg::gpp_sink_t sink;
    gpp_pkg::gpp_loop_t loop_sel;
    int n_errors = 0, n_compared = 0, cyc = 0;
    always #4 clk = ~clk;
    gpp_top uut (.CLK(clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .DIMMING_COUNT_CLOCK(dim),
        .LED_FAULT(led_fault), .SINK(sink), .LOOP_SEL(loop_sel));
    gpp_led_model u_led (.clk(clk), .sink(sink), .open_led(open_led),
        .led_fault(led_fault));
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] e, string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, e, q);
    endtask : rd
    task automatic outs(input logic [15:0] s, input logic [2:0] l);
        chk("sink_on", {16'h0, s}, {16'h0, sink.sink_on});
        chk("loop_sel", {29'h0, l}, {29'h0, loop_sel});
    endtask : outs
    // Pin stays high 8 clocks and low 9 between pulses, past the synchroniser latency
    task automatic pulse(input int k);
        repeat (k) begin
            @(posedge clk);
            dim <= 1'b1;
            repeat (8) @(posedge clk);
            dim <= 1'b0;
            repeat (8) @(posedge clk);
        end
        @(negedge clk);
    endtask : pulse
    task automatic final_report;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : final_report
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            n_errors++;
            final_report();
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(negedge clk);
        outs(16'h0000, 3'b101);
        rd(gpp_pkg::CTRL_OFS, 32'h0, "ctrl");
        rd(gpp_pkg::GS_BASE + 8'h3c, 32'h0, "gs15");
        rd(gpp_pkg::DC_BASE, 32'h0, "dc0");
        rd(8'h3c, 32'h0, "unmapped");
        chk("pslverr", 32'h1, {31'h0, err});
        apb(1'b1, gpp_pkg::DC_BASE + 8'h0c, 32'h3f);
        apb(1'b1, gpp_pkg::DC_BASE, 32'h15);
        // The last write lands on the edge the task returns at
        @(negedge clk);
        chk("dc3", 32'h3f, {26'h0, sink.dot_corr[23:18]});
        chk("dc0", 32'h15, {26'h0, sink.dot_corr[5:0]});
        rd(gpp_pkg::DC_BASE + 8'h0c, 32'h3f, "dc3 read");
        apb(1'b1, gpp_pkg::GS_BASE, 32'h2);
        apb(1'b1, gpp_pkg::GS_BASE + 8'h04, 32'h3);
        apb(1'b1, gpp_pkg::GS_BASE + 8'h14, 32'hfff);
        apb(1'b1, gpp_pkg::CTRL_OFS, 32'h2);
        pulse(1);
        outs(16'h0023, 3'b100);
        rd(gpp_pkg::STATUS_OFS, 32'h20001, "status");
        apb(1'b1, gpp_pkg::CTRL_OFS, 32'h3);
        pulse(1);
        outs(16'h0022, 3'b010);
        rd(gpp_pkg::STATUS_OFS, 32'h60002, "status");
        pulse(1);
        repeat (40) @(negedge clk);
        outs(16'h0020, 3'b010);
        rd(gpp_pkg::SINK_OFS, 32'h20, "sink reg");
        @(posedge clk) open_led <= 16'h0020;
        repeat (12) @(negedge clk);
        outs(16'h0020, 3'b101);
        rd(gpp_pkg::FAULT_OFS, 32'h20, "fault");
        @(posedge clk) open_led <= 16'h0000;
        repeat (12) @(negedge clk);
        outs(16'h0020, 3'b010);
        pulse(3581);
        outs(16'h0020, 3'b010);
        pulse(1);
        outs(16'h0020, 3'b101);
        pulse(510);
        rd(gpp_pkg::STATUS_OFS, 32'h10fff, "status");
        pulse(1);
        rd(gpp_pkg::STATUS_OFS, 32'h10000, "status");
        pulse(1);
        outs(16'h0023, 3'b010);
        apb(1'b1, gpp_pkg::CTRL_OFS, 32'h1);
        @(negedge clk);
        outs(16'h0000, 3'b101);
        pulse(1);
        rd(gpp_pkg::STATUS_OFS, 32'h10000, "status");
        final_report();
    end
endmodule : tb
`default_nettype wire
